// ===== ep12_usb_pkg.sv
// shared constants and types for the endpoint 1/2 transmit control block
package ep12_usb_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam int REG_W = 8;
  localparam int CNT_W = 4;
  localparam int EP_W = 4;
  // register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'hEB;
  localparam logic [7:0] CTL2_IDX = 8'hEC;
  localparam logic [7:0] STAT_IDX = 8'hF8;
  // transmit control fields
  localparam int TOGGLE_BIT = 7;
  localparam int SELECT_BIT = 6;
  localparam int TXEN_BIT = 5;
  localparam int RESUME_BIT = 4;
  localparam int COUNT_LSB = 0;
  // control two fields
  localparam int SOUT_BIT = 4;
  localparam int EP2EN_BIT = 3;
  localparam int EP1EN_BIT = 2;
  localparam int EP2STALL_BIT = 1;
  localparam int EP1STALL_BIT = 0;
  // status fields; done and resume detected are write one to clear, driving is read only
  localparam int DONE_BIT = 0;
  localparam int RESDET_BIT = 1;
  localparam int DRIVING_BIT = 2;
  // reset values, endpoint numbers and bus responses
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [3:0] EP_ONE = 4'h1;
  localparam logic [3:0] EP_TWO = 4'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ANSWER_DATA, ANSWER_NAK, ANSWER_STALL} answer_kind_type;
  function automatic logic reg_mapped(input logic [7:0] idx);
    return (idx == CTRL_IDX) || (idx == CTL2_IDX) || (idx == STAT_IDX);
  endfunction
endpackage

// ===== usb_axil_slave.sv
// axi4-lite slave that turns bus cycles into byte-wide register strobes
`timescale 1ns/10ps
`default_nettype none
module usb_axil_slave #(
  parameter int ADDR_WIDTH = ep12_usb_pkg::ADDR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // write channels
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ep12_usb_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [ep12_usb_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register side
  output logic reg_wr_en,
  output logic [ep12_usb_pkg::IDX_W-1:0] reg_wr_index,
  output logic [ep12_usb_pkg::REG_W-1:0] reg_wr_data,
  output logic [ep12_usb_pkg::IDX_W-1:0] reg_rd_index,
  input wire logic [ep12_usb_pkg::REG_W-1:0] reg_rd_data
);
  import ep12_usb_pkg::*;
  if (ADDR_WIDTH < 10) begin : g_bad_width
    $error("address width too small for the register map");
  end
  logic aw_got, next_aw_got, aw_ok, next_aw_ok, w_got, next_w_got, w_lane, next_w_lane;
  logic [7:0] aw_idx, next_aw_idx, w_dat, next_w_dat;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic do_write, ar_ok, aw_hit;

  // upper address bits must be zero, byte lane bits are ignored
  assign aw_hit = reg_mapped(awaddr[9:2]) && (awaddr >> 10) == '0;
  assign ar_ok = reg_mapped(araddr[9:2]) && (araddr >> 10) == '0;
  assign awready = !aw_got && !bvalid;
  assign wready = !w_got && !bvalid;
  assign arready = !rvalid;
  assign do_write = aw_got && w_got && !bvalid;
  // narrow writes that skip lane 0 leave the register alone
  assign reg_wr_en = do_write && aw_ok && w_lane;
  assign reg_wr_index = aw_idx;
  assign reg_wr_data = w_dat;
  assign reg_rd_index = araddr[9:2];

  always_comb begin
    next_aw_got = aw_got;
    next_aw_ok = aw_ok;
    next_aw_idx = aw_idx;
    next_w_got = w_got;
    next_w_dat = w_dat;
    next_w_lane = w_lane;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready) begin
      next_aw_got = 1'b1;
      next_aw_idx = awaddr[9:2];
      next_aw_ok = aw_hit;
    end
    if (wvalid && wready) begin
      next_w_got = 1'b1;
      next_w_dat = wdata[7:0];
      next_w_lane = wstrb[0];
    end
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = aw_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rdata = ar_ok ? {24'h000000, reg_rd_data} : 32'h00000000;
      next_rresp = ar_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      aw_ok <= 1'b0;
      aw_idx <= 8'h00;
      w_got <= 1'b0;
      w_dat <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      aw_got <= next_aw_got;
      aw_ok <= next_aw_ok;
      aw_idx <= next_aw_idx;
      w_got <= next_w_got;
      w_dat <= next_w_dat;
      w_lane <= next_w_lane;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule // usb_axil_slave
`default_nettype wire

// ===== ep12_in_responder.sv
// handshake decision for in tokens aimed at endpoint 1 or 2
`timescale 1ns/10ps
`default_nettype none
module ep12_in_responder (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // token from the serial engine
  input wire logic in_token,
  input wire logic [ep12_usb_pkg::EP_W-1:0] in_endpoint,
  // control state
  input wire logic tx_enable,
  input wire logic done_flag,
  input wire logic select_two,
  input wire logic ep1_enable,
  input wire logic ep2_enable,
  input wire logic ep1_stall,
  input wire logic ep2_stall,
  input wire logic toggle,
  input wire logic [ep12_usb_pkg::CNT_W-1:0] count,
  // answer to the serial engine
  output logic answer_valid,
  output ep12_usb_pkg::answer_kind_type answer_kind,
  output logic answer_data1,
  output logic [ep12_usb_pkg::CNT_W-1:0] answer_count
);
  import ep12_usb_pkg::*;
  logic is_one, is_two, stall, ok, next_valid, next_data1;
  answer_kind_type next_kind;
  logic [CNT_W-1:0] next_count;

  assign is_one = in_endpoint == EP_ONE;
  assign is_two = in_endpoint == EP_TWO;

  always_comb begin
    stall = is_one ? ep1_stall : ep2_stall;
    // both endpoints share one buffer, so only the selected one may send
    ok = tx_enable && !done_flag && (is_two ? (ep2_enable && select_two) : //R1 R2 R5
      (ep1_enable && !select_two));
    next_valid = in_token && (is_one || is_two);
    next_kind = answer_kind;
    next_data1 = answer_data1;
    next_count = answer_count;
    if (next_valid) begin
      next_kind = stall ? ANSWER_STALL : (ok ? ANSWER_DATA : ANSWER_NAK); //R2
      next_data1 = toggle; //R12
      next_count = count; //R11
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      answer_valid <= 1'b0;
      answer_kind <= ANSWER_NAK;
      answer_data1 <= 1'b0;
      answer_count <= '0;
    end else begin
      answer_valid <= next_valid;
      answer_kind <= next_kind;
      answer_data1 <= next_data1;
      answer_count <= next_count;
    end
  end
endmodule // ep12_in_responder
`default_nettype wire

// ===== usb_ep12_transmit_control.sv
// endpoint 1/2 transmit control with register file and resume drive
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: transmit enable lets endpoint 1 or 2 send
// R2: enable off or done flag answers NAK; the code answers STALL instead when the endpoint stall bit is set
// R3: software also sets the per-endpoint enable
// R4: software sets enable when ready, clears after
// R5: endpoint 2 NAKs while selector picks endpoint 1; the code answers STALL instead when the endpoint 2 stall bit is set
// R6: reset clears the endpoint selector
// R7: reset clears the shared transmit enable
// R8: force resume drives K on the lines
// R9: software times resume between 10 and 15 ms
// R10: force resume never sets resume detected flag
// R11: low four bits hold next packet byte count
// R12: bit 7 picks DATA0 or DATA1 PID
module usb_ep12_transmit_control #(
  parameter int ADDR_WIDTH = ep12_usb_pkg::ADDR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ep12_usb_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [ep12_usb_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // usb serial engine
  input wire logic in_token,
  input wire logic [ep12_usb_pkg::EP_W-1:0] in_endpoint,
  input wire logic tx_packet_acked,
  input wire logic resume_seen,
  output logic answer_valid,
  output ep12_usb_pkg::answer_kind_type answer_kind,
  output logic answer_data1,
  output logic [ep12_usb_pkg::CNT_W-1:0] answer_count,
  // data line drive for resume
  output logic resume_dp,
  output logic resume_dm,
  output logic resume_oe
);
  import ep12_usb_pkg::*;
  // the slave decodes index bits 9..2, so narrower buses cannot reach the map
  if (ADDR_WIDTH < 10 || ADDR_WIDTH > DATA_W) begin : g_bad_addr
    $error("address width cannot serve the register map");
  end

  logic wr_en;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  logic [REG_W-1:0] wr_dat, rd_dat;
  logic [REG_W-1:0] ctrl, next_ctrl, ctl2, next_ctl2;
  logic done_flag, next_done_flag, resume_detected_flag, next_resume_detected_flag;
  logic next_oe;
  logic ep12_data_toggle, endpoint_one_two_select, ep12_transmit_enable, force_resume;
  logic endpoint_one_enable, endpoint_two_enable, endpoint_one_stall, endpoint_two_stall;
  logic [CNT_W-1:0] tx_count;

  usb_axil_slave #(
    .ADDR_WIDTH(ADDR_WIDTH)
  ) u_bus (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .reg_wr_en(wr_en),
    .reg_wr_index(wr_idx),
    .reg_wr_data(wr_dat),
    .reg_rd_index(rd_idx),
    .reg_rd_data(rd_dat)
  );

  assign ep12_data_toggle = ctrl[TOGGLE_BIT];
  assign endpoint_one_two_select = ctrl[SELECT_BIT];
  assign ep12_transmit_enable = ctrl[TXEN_BIT];
  assign force_resume = ctrl[RESUME_BIT];
  assign tx_count = ctrl[COUNT_LSB +: CNT_W];
  assign endpoint_two_enable = ctl2[EP2EN_BIT];
  assign endpoint_one_enable = ctl2[EP1EN_BIT];
  assign endpoint_two_stall = ctl2[EP2STALL_BIT];
  assign endpoint_one_stall = ctl2[EP1STALL_BIT];

  // register writes and sticky flags
  always_comb begin
    next_ctrl = ctrl;
    next_ctl2 = ctl2;
    next_done_flag = done_flag;
    next_resume_detected_flag = resume_detected_flag;
    if (wr_en && wr_idx == CTRL_IDX) begin
      next_ctrl = wr_dat; //R11 R12
    end
    if (wr_en && wr_idx == CTL2_IDX) begin
      // reserved bits 7..5 are kept at zero
      next_ctl2 = {3'h0, wr_dat[4:0]};
    end
    if (wr_en && wr_idx == STAT_IDX) begin
      if (wr_dat[DONE_BIT]) begin
        next_done_flag = 1'b0;
      end
      if (wr_dat[RESDET_BIT]) begin
        next_resume_detected_flag = 1'b0;
      end
    end
    // a set in the same cycle as a clear wins
    if (tx_packet_acked) begin
      next_done_flag = 1'b1;
    end
    // own K drive echoes back on the lines and must not look like a host resume
    if (resume_seen && !force_resume && !resume_oe) begin //R10
      next_resume_detected_flag = 1'b1;
    end
  end

  // K state: D+ low, D- high; the bit is level, software owns the timing
  assign next_oe = force_resume; //R8

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST; //R6 R7 R11
      ctl2 <= CTL2_RST;
      done_flag <= 1'b0;
      resume_detected_flag <= 1'b0;
      resume_oe <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      ctl2 <= next_ctl2;
      done_flag <= next_done_flag;
      resume_detected_flag <= next_resume_detected_flag;
      resume_oe <= next_oe; //R8
    end
  end

  assign resume_dp = 1'b0;
  assign resume_dm = resume_oe;

  // read mux; unmapped indices answer zero and are flagged by the bus slave
  always_comb begin
    case (rd_idx)
      CTRL_IDX: rd_dat = ctrl;
      CTL2_IDX: rd_dat = ctl2;
      STAT_IDX: rd_dat = {5'h00, resume_oe, resume_detected_flag, done_flag};
      default: rd_dat = 8'h00;
    endcase
  end

  ep12_in_responder u_resp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_token(in_token),
    .in_endpoint(in_endpoint),
    .tx_enable(ep12_transmit_enable),
    .done_flag(done_flag),
    .select_two(endpoint_one_two_select),
    .ep1_enable(endpoint_one_enable),
    .ep2_enable(endpoint_two_enable),
    .ep1_stall(endpoint_one_stall),
    .ep2_stall(endpoint_two_stall),
    .toggle(ep12_data_toggle),
    .count(tx_count),
    .answer_valid(answer_valid),
    .answer_kind(answer_kind),
    .answer_data1(answer_data1),
    .answer_count(answer_count)
  );

  logic tok_one, tok_two, tok_stall;
  assign tok_one = in_token && in_endpoint == EP_ONE;
  assign tok_two = in_token && in_endpoint == EP_TWO;
  assign tok_stall = tok_one ? endpoint_one_stall : endpoint_two_stall;

  a_data_allowed: assert property ( //R1
    @(posedge clk_sys) disable iff (!rst_n)
    tok_two && ep12_transmit_enable && !done_flag && endpoint_two_enable
      && !endpoint_two_stall && endpoint_one_two_select
      |=> answer_valid && answer_kind == ANSWER_DATA)
    else $error("enabled endpoint 2 token did not send data");

  a_nak_when_off: assert property ( //R2
    @(posedge clk_sys) disable iff (!rst_n)
    (tok_one || tok_two) && !tok_stall && (!ep12_transmit_enable || done_flag)
      |=> answer_valid && answer_kind == ANSWER_NAK)
    else $error("token with transmit off or done did not get NAK");

  a_select_nak: assert property ( //R5
    @(posedge clk_sys) disable iff (!rst_n)
    tok_two && !endpoint_one_two_select && !endpoint_two_stall
      |=> answer_valid && answer_kind != ANSWER_DATA)
    else $error("endpoint 2 sent data while endpoint 1 selected");

  a_reset_clears: assert property ( //R6
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> !endpoint_one_two_select && !ep12_transmit_enable && tx_count == 4'h0)
    else $error("control fields not clear after reset");

  a_enable_kept: assert property ( //R7
    @(posedge clk_sys) disable iff (!rst_n)
    !ep12_transmit_enable && !(wr_en && wr_idx == CTRL_IDX) |=> !ep12_transmit_enable)
    else $error("transmit enable set without a write");

  a_resume_drive: assert property ( //R8
    @(posedge clk_sys) disable iff (!rst_n)
    force_resume [*2] |-> resume_oe && !resume_dp && resume_dm)
    else $error("forced resume not driving K");

  a_no_self_resume: assert property ( //R10
    @(posedge clk_sys) disable iff (!rst_n)
    force_resume && !resume_detected_flag |=> !resume_detected_flag)
    else $error("forced resume set the resume detected flag");

  a_count_write: assert property ( //R11
    @(posedge clk_sys) disable iff (!rst_n)
    wr_en && wr_idx == CTRL_IDX |=> tx_count == $past(wr_dat[3:0]))
    else $error("byte count not taken from the write");

  a_pid_follows: assert property ( //R12
    @(posedge clk_sys) disable iff (!rst_n)
    (tok_one || tok_two) |=> answer_data1 == $past(ep12_data_toggle))
    else $error("data pid does not follow the toggle bit");

  a_done_set_wins: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    tx_packet_acked |=> done_flag)
    else $error("transmit done lost against a clear");

  a_ep1_data: assert property ( //R1
    @(posedge clk_sys) disable iff (!rst_n)
    tok_one && ep12_transmit_enable && !done_flag && endpoint_one_enable
      && !endpoint_one_stall && !endpoint_one_two_select
      |=> answer_valid && answer_kind == ANSWER_DATA)
    else $error("enabled endpoint 1 token did not send data");

  a_ep1_select_nak: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    tok_one && endpoint_one_two_select && !endpoint_one_stall
      |=> answer_valid && answer_kind == ANSWER_NAK)
    else $error("endpoint 1 sent data while endpoint 2 selected");

  a_stall_answer: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (tok_one || tok_two) && tok_stall |=> answer_valid && answer_kind == ANSWER_STALL)
    else $error("stalled endpoint did not answer STALL");

  a_answer_pulse: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(tok_one || tok_two) |=> !answer_valid)
    else $error("answer given without a token");

  a_count_follows: assert property ( //R11
    @(posedge clk_sys) disable iff (!rst_n)
    (tok_one || tok_two) |=> answer_count == $past(tx_count))
    else $error("answer byte count does not follow the register");

  a_toggle_write: assert property ( //R12
    @(posedge clk_sys) disable iff (!rst_n)
    wr_en && wr_idx == CTRL_IDX |=> ep12_data_toggle == $past(wr_dat[TOGGLE_BIT]))
    else $error("data toggle not taken from the write");

  a_resume_release: assert property ( //R8
    @(posedge clk_sys) disable iff (!rst_n)
    !force_resume [*2] |-> !resume_oe && !resume_dm)
    else $error("resume drive left on after clear");

  a_host_resume_flag: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    resume_seen && !force_resume && !resume_oe |=> resume_detected_flag)
    else $error("host resume not recorded");

  a_done_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wr_en && wr_idx == STAT_IDX && wr_dat[DONE_BIT] && !tx_packet_acked |=> !done_flag)
    else $error("transmit done not cleared by a write");

  a_ctl2_reserved: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ctl2[7:5] == 3'h0)
    else $error("reserved control two bits set");

endmodule // usb_ep12_transmit_control
`default_nettype wire

// ===== usb_host_model.sv
// host controller model that issues in tokens and records the answers
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // token side
  output var logic in_token,
  output var logic [ep12_usb_pkg::EP_W-1:0] in_endpoint,
  output var logic tx_packet_acked,
  output var logic resume_seen,
  // answer side
  input wire logic answer_valid,
  input wire ep12_usb_pkg::answer_kind_type answer_kind,
  input wire logic answer_data1,
  input wire logic [ep12_usb_pkg::CNT_W-1:0] answer_count
);
  import ep12_usb_pkg::*;
  logic got_valid, got_data1;
  logic [1:0] got_kind;
  logic [CNT_W-1:0] got_count;
  initial begin
    in_token = 1'b0;
    in_endpoint = 4'h0;
    tx_packet_acked = 1'b0;
    resume_seen = 1'b0;
  end
  // gap gives a slow host; idle endpoint lines show the inverse, not a held value
  task automatic send_in(input logic [EP_W-1:0] ep, input int gap);
    repeat (gap + 1) @(posedge clk_sys);
    in_token <= 1'b1;
    in_endpoint <= ep;
    @(posedge clk_sys);
    in_token <= 1'b0;
    in_endpoint <= ~ep;
    @(negedge clk_sys);
    got_valid = answer_valid;
    got_kind = answer_kind;
    got_data1 = answer_data1;
    got_count = answer_count;
  endtask
  // acknowledge of the last in data packet, one cycle
  task automatic ack();
    @(posedge clk_sys);
    tx_packet_acked <= 1'b1;
    @(posedge clk_sys);
    tx_packet_acked <= 1'b0;
  endtask
  task automatic set_resume(input logic v);
    @(posedge clk_sys);
    resume_seen <= v;
  endtask
endmodule // usb_host_model
`default_nettype wire

// ===== usb_ep12_transmit_control_test.sv
// self-checking bench for the endpoint 1/2 transmit control block
`timescale 1ns/10ps
`default_nettype none
module usb_ep12_transmit_control_test;
  import ep12_usb_pkg::*;
  localparam logic [11:0] A_CTRL = {2'b00, CTRL_IDX, 2'b00};
  localparam logic [11:0] A_CTL2 = {2'b00, CTL2_IDX, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, STAT_IDX, 2'b00};
  localparam logic [11:0] A_NONE = 12'h3B4;
  logic clk_sys, rst_n;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, in_endpoint, answer_count;
  logic [1:0] bresp, rresp;
  logic in_token, tx_packet_acked, resume_seen, answer_valid, answer_data1;
  logic resume_dp, resume_dm, resume_oe;
  answer_kind_type answer_kind;
  int error_cnt = 0;
  int check_count = 0;

  usb_ep12_transmit_control dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .in_token(in_token),
    .in_endpoint(in_endpoint), .tx_packet_acked(tx_packet_acked), .resume_seen(resume_seen),
    .answer_valid(answer_valid), .answer_kind(answer_kind), .answer_data1(answer_data1),
    .answer_count(answer_count), .resume_dp(resume_dp), .resume_dm(resume_dm),
    .resume_oe(resume_oe)
  );
  usb_host_model host (
    .clk_sys(clk_sys), .rst_n(rst_n), .in_token(in_token), .in_endpoint(in_endpoint),
    .tx_packet_acked(tx_packet_acked), .resume_seen(resume_seen), .answer_valid(answer_valid),
    .answer_kind(answer_kind), .answer_data1(answer_data1), .answer_count(answer_count)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // each channel is released at the edge that takes it; handshakes sampled before that edge
  task automatic axw(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_go, w_go, b_go;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_go = 1'b0;
    while (!b_go) begin
      @(negedge clk_sys);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      r = bresp;
      @(posedge clk_sys);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_go, r_go;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_go = 1'b0;
    while (!r_go) begin
      @(negedge clk_sys);
      ar_go = arvalid && arready;
      r_go = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
      if (ar_go) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic tok(input logic [3:0] ep, input int gap, input logic ev, input logic [1:0] ek,
                     input logic ed, input logic [3:0] ec);
    host.send_in(ep, gap);
    chk({31'h0, host.got_valid}, {31'h0, ev});
    if (ev) begin
      chk({30'h0, host.got_kind}, {30'h0, ek});
      chk({27'h0, host.got_data1, host.got_count}, {27'h0, ed, ec});
    end
  endtask

  initial begin
    int cyc;
    cyc = 0;
    while (cyc < 20000) begin
      @(posedge clk_sys);
      cyc++;
    end
    error_cnt++;
    end_of_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    rst_n = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(A_CTRL, 32'h0);
    rd_chk(A_CTL2, 32'h0);
    tok(EP_ONE, 0, 1'b1, ANSWER_NAK, 1'b0, 4'h0);
    tok(EP_TWO, 3, 1'b1, ANSWER_NAK, 1'b0, 4'h0);
    // unmapped place: write ignored, read gives zero, both refused
    axw(A_NONE, 8'hFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axr(A_NONE, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(A_CTL2, 8'h0C);
    wr(A_CTRL, 8'hA5);
    rd_chk(A_CTRL, 32'hA5);
    tok(EP_ONE, 0, 1'b1, ANSWER_DATA, 1'b1, 4'h5);
    tok(EP_TWO, 0, 1'b1, ANSWER_NAK, 1'b1, 4'h5);
    tok(4'h3, 0, 1'b0, ANSWER_NAK, 1'b0, 4'h0);
    wr(A_CTRL, 8'h6A);
    tok(EP_TWO, 2, 1'b1, ANSWER_DATA, 1'b0, 4'hA);
    tok(EP_ONE, 0, 1'b1, ANSWER_NAK, 1'b0, 4'hA);
    host.ack();
    tok(EP_TWO, 0, 1'b1, ANSWER_NAK, 1'b0, 4'hA);
    wr(A_STAT, 8'h01);
    tok(EP_TWO, 0, 1'b1, ANSWER_DATA, 1'b0, 4'hA);
    wr(A_CTRL, 8'h4A);
    tok(EP_TWO, 0, 1'b1, ANSWER_NAK, 1'b0, 4'hA);
    // reserved bits read zero; a stalled endpoint beats the nak
    wr(A_CTL2, 8'hFE);
    rd_chk(A_CTL2, 32'h1E);
    tok(EP_TWO, 0, 1'b1, ANSWER_STALL, 1'b0, 4'hA);
    tok(EP_ONE, 0, 1'b1, ANSWER_NAK, 1'b0, 4'hA);
    // forced resume: k state while set, and the host resume flag stays clear
    wr(A_CTRL, 8'h10);
    @(negedge clk_sys);
    chk({29'h0, resume_dp, resume_dm, resume_oe}, 32'h3);
    host.set_resume(1'b1);
    repeat (4) @(posedge clk_sys);
    rd_chk(A_STAT, 32'h4);
    host.set_resume(1'b0);
    wr(A_CTRL, 8'h00);
    @(negedge clk_sys);
    chk({29'h0, resume_dp, resume_dm, resume_oe}, 32'h0);
    host.set_resume(1'b1);
    host.set_resume(1'b0);
    rd_chk(A_STAT, 32'h2);
    // second reset in mid-run clears every transmit control field again
    wr(A_CTRL, 8'hFF);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(A_CTRL, 32'h0);
    end_of_test();
  end
endmodule // usb_ep12_transmit_control_test
`default_nettype wire
